//--- logic/embp_defines.svh
// Constants of the Ethernet bridge port: register indices, fields,
// reset values and timing counts. Included by the poller and top design files.
`ifndef EMBP_DEFINES_SVH
`define EMBP_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define EMBP_IDX_MODE   8'h01
`define EMBP_IDX_ADDR   8'h1e
`define EMBP_IDX_COAX   8'h26
`define EMBP_IDX_STAT   8'h44
`define EMBP_IDX_IRQ    8'h48
`define EMBP_IDX_MASK   8'h49

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define EMBP_RMII_BIT   0
`define EMBP_CLKSRC_BIT 1
`define EMBP_MODE_LO    3
`define EMBP_ADDR_LO    4
`define EMBP_OVR_BIT    0
`define EMBP_TXEN_BIT   3
`define EMBP_RXEN_BIT   4
`define EMBP_LINK_BIT   3
`define EMBP_MODE_MAC   2'h0
`define EMBP_MODE_PHY   2'h1
`define EMBP_MODE_PASS  2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EMBP_MODE_RST   8'h00
`define EMBP_ADDR_RST   8'h00
`define EMBP_COAX_RST   8'h00

// ----------------------------------------------------------------------
// Timing and management frame layout
// ----------------------------------------------------------------------
`define EMBP_MDC_XTAL   8
`define EMBP_MDC_HALF   (`EMBP_MDC_XTAL / 2)
`define EMBP_POLL_GAP   8'h40
`define EMBP_GENCLK_HALF 4'h4
`define EMBP_BMSR_REG   5'h01
`define EMBP_FRAME_LAST 6'h3f
`define EMBP_TA_FIRST   6'h2e
`define EMBP_LINK_SLOT  6'h3d

`endif

//--- logic/embp_pkg.sv
// Types shared by the Ethernet bridge port files.
// Assumes the defines header supplies all numbers.
package embp_pkg;

  // One nibble lane: data, error, valid or enable
  typedef struct packed {
    logic [3:0] d;
    logic       er;
    logic       vld;
  } embp_nib_type;

  // Management poller states
  typedef enum logic [0:0] {
    EMBP_GAP,
    EMBP_FRAME
  } embp_mgmt_type;

endpackage

//--- logic/embp_sync.sv
// Two-flop synchroniser for pin inputs of the bridge port.
// Assumes each bit is an independent level from outside clk_i.
`timescale 1ns/1ps
module embp_sync #(
  parameter int W = 19
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule

//--- logic/embp_mdio_poll.sv
// Management master that polls the external PHY link bit.
// Assumes mdio_i is already synchronised to clk_i.
`timescale 1ns/1ps
`include "embp_defines.svh"
module embp_mdio_poll (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       active_i,
  input  wire logic [4:0] phy_addr_i,
  input  wire logic       mdio_i,
  output logic            mdc_o,
  output logic            mdio_o,
  output logic            mdio_oe_o,
  output logic            link_o,
  output logic            done_o
);

  logic [2:0]             phase_ff;
  logic [5:0]             bit_ff;
  logic [7:0]             gap_ff;
  logic                   cap_ff;
  embp_pkg::embp_mgmt_type st_ff;
  logic [63:0]            frame;

  // Read frame: preamble, start, read op, address, register
  assign frame = {32'hffffffff, 2'h1, 2'h2, phy_addr_i,
                  `EMBP_BMSR_REG, 18'h3ffff};

  // R7 eight-cycle clock
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_ff <= 3'h0;
      mdc_o    <= 1'b0;
    end else if (!active_i) begin
      phase_ff <= 3'h0;
      mdc_o    <= 1'b0;
    end else begin
      phase_ff <= phase_ff + 3'h1;
      if (phase_ff == 3'(`EMBP_MDC_HALF - 1)) begin
        mdc_o <= 1'b1;
      end else if (phase_ff == 3'(`EMBP_MDC_XTAL - 1)) begin
        mdc_o <= 1'b0;
      end
    end
  end

  // R3 R4 periodic read, bits change as the clock falls
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff     <= embp_pkg::EMBP_GAP;
      gap_ff    <= 8'h00;
      bit_ff    <= 6'h00;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
      done_o    <= 1'b0;
    end else if (!active_i) begin
      st_ff     <= embp_pkg::EMBP_GAP;
      gap_ff    <= 8'h00;
      mdio_oe_o <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (phase_ff == 3'(`EMBP_MDC_XTAL - 1)) begin
        case (st_ff)
          embp_pkg::EMBP_GAP: begin
            gap_ff <= gap_ff + 8'h01;
            if (gap_ff == `EMBP_POLL_GAP - 8'h01) begin
              st_ff     <= embp_pkg::EMBP_FRAME;
              gap_ff    <= 8'h00;
              bit_ff    <= 6'h00;
              mdio_o    <= frame[63];
              mdio_oe_o <= 1'b1;
            end
          end
          embp_pkg::EMBP_FRAME: begin
            if (bit_ff == `EMBP_FRAME_LAST) begin
              st_ff  <= embp_pkg::EMBP_GAP;
              done_o <= 1'b1;
            end else begin
              bit_ff    <= bit_ff + 6'h01;
              mdio_o    <= frame[6'h3e - bit_ff];
              // R14 release for turnaround and data
              mdio_oe_o <= (bit_ff + 6'h01) < `EMBP_TA_FIRST;
            end
          end
          default: st_ff <= embp_pkg::EMBP_GAP;
        endcase
      end
    end
  end

  // R14 link bit taken from status word
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_ff <= 1'b0;
      link_o <= 1'b0;
    end else if (!active_i) begin
      link_o <= 1'b0;
    end else begin
      if (st_ff == embp_pkg::EMBP_FRAME && bit_ff == `EMBP_LINK_SLOT &&
          phase_ff == 3'(`EMBP_MDC_HALF - 1)) begin
        cap_ff <= mdio_i;
      end
      if (done_o) begin
        link_o <= cap_ff;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence mdc_high_s;
    mdc_o [*4];
  endsequence

  // Leaving MAC mode cuts a high phase short, so that case is excluded
  mdc_duty_a: assert property (disable iff (sys_rst_i || !active_i) // R7
    $rose(mdc_o) |-> mdc_high_s ##1 !mdc_o)
    else $error("mdc high phase not four cycles");
  idle_quiet_a: assert property (!active_i |=> !mdio_oe_o && !mdc_o) // R3
    else $error("management bus driven outside mac mode");
  ta_release_a: assert property (st_ff == embp_pkg::EMBP_FRAME && // R14
    bit_ff >= `EMBP_TA_FIRST && phase_ff == 3'h2 |-> !mdio_oe_o)
    else $error("mdio driven during turnaround or data");
  start_bit_a: assert property (bit_ff == 6'h20 && mdio_oe_o && // R4
    st_ff == embp_pkg::EMBP_FRAME |-> !mdio_o)
    else $error("start field wrong");

endmodule

//--- logic/embp_top.sv
// Ethernet MII/RMII bridge port: MAC role, PHY role, passthrough,
// link polling over the management bus, APB registers and interrupt.
// Assumes one 40 MHz clock; all pins but the APB bus and the user side are asynchronous to it.
//
// Notes on behaviour
// R1: Mode A acts as MAC toward a PHY, mode B as PHY toward a MAC.
// R2: Only 100 Mbit operation; no 10 Mbit mode exists.
// R3: Management bus runs only in MAC mode.
// R4: Management master periodically reads the PHY link state.
// R5: PHY address is config bits 6:4, then high strap, then low strap.
// R6: Software and straps make that address match the attached PHY.
// R7: Management clock period is eight core clocks, near even duty.
// R8: RMII reference from the PHY, or from the auxiliary pin if selected.
// R9: Mode field value 10b joins the two ports in passthrough.
// R10: Receive flows PHY to MAC side; transmit MAC to PHY side.
// R11: RMII passthrough registers every signal on the reference clock; the forwarded MAC clocks are resampled on every core clock.
// R12: Status bit shows the polled link: 1 up, 0 down.
// R13: Coax enables follow link unless override selects manual bits.
// R14: Each poll is a clause-22 read of the basic status register.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "embp_defines.svh"
module embp_top (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic                   addr_strap_hi_pin_i,
  input  wire logic                   addr_strap_lo_pin_i,
  output logic                        mdc_o,
  input  wire logic                   mdio_i,
  output logic                        mdio_o,
  output logic                        mdio_oe_o,
  input  wire logic                   phy_ref_clk_i,
  input  wire logic                   aux_ref_clk_i,
  input  wire logic                   phy_rx_clk_i,
  input  wire embp_pkg::embp_nib_type phy_rx_i,
  input  wire logic                   phy_tx_clk_i,
  output embp_pkg::embp_nib_type      phy_tx_o,
  output logic                        mac_rx_clk_o,
  output embp_pkg::embp_nib_type      mac_rx_o,
  output logic                        mac_tx_clk_o,
  input  wire embp_pkg::embp_nib_type mac_tx_i,
  input  wire embp_pkg::embp_nib_type usr_tx_i,
  output logic                        usr_tx_take_o,
  output embp_pkg::embp_nib_type      usr_rx_o,
  output logic                        usr_rx_stb_o,
  output logic                        coax_tx_en_o,
  output logic                        coax_rx_en_o,
  output logic                        irq_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisation and edge finding
  // ----------------------------------------------------------------------
  logic [18:0]            pins_s;
  logic                   rxclk_s;
  logic                   txclk_s;
  logic                   pref_s;
  logic                   aref_s;
  logic                   mdio_s;
  logic                   hi_s;
  logic                   lo_s;
  embp_pkg::embp_nib_type phy_rx_s;
  embp_pkg::embp_nib_type mac_tx_s;
  logic                   ref_s;
  logic [2:0]             prev_ff;
  logic                   rxclk_rise;
  logic                   txclk_rise;
  logic                   ref_rise;

  embp_sync #(
    .W (19)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({phy_rx_clk_i, phy_rx_i, phy_tx_clk_i, phy_ref_clk_i,
                 aux_ref_clk_i, mac_tx_i, mdio_i, addr_strap_hi_pin_i,
                 addr_strap_lo_pin_i}),
    .q_o       (pins_s)
  );

  assign {rxclk_s, phy_rx_s, txclk_s, pref_s, aref_s, mac_tx_s, mdio_s,
          hi_s, lo_s} = pins_s;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] mode_reg_ff;
  logic [7:0] addr_reg_ff;
  logic [7:0] coax_reg_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [1:0] mode;
  logic       rmii;
  logic       link;
  logic       poll_done;
  logic       link_prev_ff;
  logic [7:0] idx;
  logic       wr_en;
  logic [2:0] events;

  assign mode = mode_reg_ff[`EMBP_MODE_LO +: 2];
  assign rmii = mode_reg_ff[`EMBP_RMII_BIT];

  // R8 reference clock source select
  assign ref_s = mode_reg_ff[`EMBP_CLKSRC_BIT] ? aref_s : pref_s;

  // Previous levels for edge finding; reads second stage only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_ff <= 3'h0;
    end else begin
      prev_ff <= {rxclk_s, txclk_s, ref_s};
    end
  end

  assign rxclk_rise = rxclk_s & ~prev_ff[2];
  assign txclk_rise = txclk_s & ~prev_ff[1];
  assign ref_rise   = ref_s & ~prev_ff[0];

  // ----------------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == `EMBP_IDX_MODE) || (i == `EMBP_IDX_ADDR) ||
                (i == `EMBP_IDX_COAX) || (i == `EMBP_IDX_STAT) ||
                (i == `EMBP_IDX_IRQ)  || (i == `EMBP_IDX_MASK);
  endfunction

  assign idx   = paddr_i[9:2];
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

  // Answer comes in the second access cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= 1'b0;
      if (psel_i & penable_i & ~pready_o) begin
        pslverr_o <= ~is_mapped(idx) | (paddr_i[11:10] != 2'h0);
        case (idx)
          `EMBP_IDX_MODE: prdata_o <= {24'h000000, mode_reg_ff};
          `EMBP_IDX_ADDR: prdata_o <= {24'h000000, addr_reg_ff};
          `EMBP_IDX_COAX: prdata_o <= {24'h000000, coax_reg_ff};
          // R12 polled link status
          `EMBP_IDX_STAT: prdata_o <= {28'h0000000, link, 3'h0};
          `EMBP_IDX_IRQ:  prdata_o <= {29'h00000000, irq_stat_ff};
          `EMBP_IDX_MASK: prdata_o <= {29'h00000000, irq_mask_ff};
          default:        prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Writable configuration
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_reg_ff <= `EMBP_MODE_RST;
      addr_reg_ff <= `EMBP_ADDR_RST;
      coax_reg_ff <= `EMBP_COAX_RST;
      irq_mask_ff <= 3'h0;
    end else if (wr_en) begin
      case (idx)
        `EMBP_IDX_MODE: mode_reg_ff <= pwdata_i[7:0];
        `EMBP_IDX_ADDR: addr_reg_ff <= pwdata_i[7:0];
        `EMBP_IDX_COAX: coax_reg_ff <= pwdata_i[7:0];
        `EMBP_IDX_MASK: irq_mask_ff <= pwdata_i[2:0];
        default:        irq_mask_ff <= irq_mask_ff;
      endcase
    end
  end

  // Sticky events; a new event wins over a write-one clear
  assign events = {poll_done, ~link & link_prev_ff, link & ~link_prev_ff};

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_ff  <= 3'h0;
      link_prev_ff <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      link_prev_ff <= link;
      irq_stat_ff  <= (irq_stat_ff &
                      ~((wr_en && idx == `EMBP_IDX_IRQ) ? pwdata_i[2:0] : 3'h0))
                      | events;
      irq_o        <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------------
  // Management polling
  // ----------------------------------------------------------------------
  logic [4:0] phy_addr;

  // R5 address from register and straps
  assign phy_addr = {addr_reg_ff[`EMBP_ADDR_LO +: 3], hi_s, lo_s};

  // R3 only active in MAC role
  embp_mdio_poll u_mdio (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .active_i   (mode == `EMBP_MODE_MAC),
    .phy_addr_i (phy_addr),
    .mdio_i     (mdio_s),
    .mdc_o      (mdc_o),
    .mdio_o     (mdio_o),
    .mdio_oe_o  (mdio_oe_o),
    .link_o     (link),
    .done_o     (poll_done)
  );

  // R13 automatic or manual coax enables
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      coax_tx_en_o <= 1'b0;
      coax_rx_en_o <= 1'b0;
    end else if (coax_reg_ff[`EMBP_OVR_BIT]) begin
      coax_tx_en_o <= coax_reg_ff[`EMBP_TXEN_BIT];
      coax_rx_en_o <= coax_reg_ff[`EMBP_RXEN_BIT];
    end else begin
      coax_tx_en_o <= link;
      coax_rx_en_o <= link;
    end
  end

  // ----------------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------------
  logic [3:0]             gen_cnt_ff;
  logic                   gen_clk_ff;
  logic                   gen_rise;
  logic                   tx_tick;
  logic                   rx_tick;
  embp_pkg::embp_nib_type usr_gated;

  // Local nibble clock for the PHY role; rate fixed, no speed select
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gen_cnt_ff <= 4'h0;
      gen_clk_ff <= 1'b0;
    end else if (gen_cnt_ff == `EMBP_GENCLK_HALF - 4'h1) begin
      gen_cnt_ff <= 4'h0;
      gen_clk_ff <= ~gen_clk_ff;
    end else begin
      gen_cnt_ff <= gen_cnt_ff + 4'h1;
    end
  end

  assign gen_rise  = (gen_cnt_ff == `EMBP_GENCLK_HALF - 4'h1) & ~gen_clk_ff;
  // R2 single 100 Mbit timing, RMII on the reference clock
  assign tx_tick   = rmii ? ref_rise :
                     (mode == `EMBP_MODE_MAC ? txclk_rise : gen_rise);
  assign rx_tick   = rmii ? ref_rise :
                     (mode == `EMBP_MODE_MAC ? rxclk_rise : gen_rise);
  assign usr_gated = '{d: usr_tx_i.d, er: usr_tx_i.er,
                       vld: usr_tx_i.vld & coax_rx_en_o};

  // R1 port facing the external PHY or MAC
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phy_tx_o      <= '0;
      mac_rx_o      <= '0;
      usr_tx_take_o <= 1'b0;
    end else begin
      usr_tx_take_o <= 1'b0;
      case (mode)
        `EMBP_MODE_MAC: begin
          mac_rx_o <= '0;
          if (tx_tick) begin
            phy_tx_o      <= usr_gated;
            usr_tx_take_o <= 1'b1;
          end
        end
        `EMBP_MODE_PHY: begin
          phy_tx_o <= '0;
          if (tx_tick) begin
            mac_rx_o      <= usr_gated;
            usr_tx_take_o <= 1'b1;
          end
        end
        // R9 R10 R11 passthrough, RMII on reference edges
        `EMBP_MODE_PASS: begin
          if (!rmii || ref_rise) begin
            mac_rx_o <= phy_rx_s;
            phy_tx_o <= mac_tx_s;
          end
        end
        default: begin
          phy_tx_o <= '0;
          mac_rx_o <= '0;
        end
      endcase
    end
  end

  // R10 forwarded or generated clocks
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mac_rx_clk_o <= 1'b0;
      mac_tx_clk_o <= 1'b0;
    end else begin
      mac_rx_clk_o <= (mode == `EMBP_MODE_PASS) ? rxclk_s :
                      (mode == `EMBP_MODE_PHY) & gen_clk_ff;
      mac_tx_clk_o <= (mode == `EMBP_MODE_PASS) ? txclk_s :
                      (mode == `EMBP_MODE_PHY) & gen_clk_ff;
    end
  end

  // R1 received nibbles toward the user side
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      usr_rx_o     <= '0;
      usr_rx_stb_o <= 1'b0;
    end else begin
      usr_rx_stb_o <= 1'b0;
      if (rx_tick && (mode == `EMBP_MODE_MAC || mode == `EMBP_MODE_PHY)) begin
        usr_rx_o     <= (mode == `EMBP_MODE_MAC) ? phy_rx_s : mac_tx_s;
        usr_rx_stb_o <= coax_tx_en_o;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence pass_mii_s;
    mode == `EMBP_MODE_PASS && !rmii;
  endsequence

  auto_enable_a: assert property (!coax_reg_ff[`EMBP_OVR_BIT] ##1 // R13
    !coax_reg_ff[`EMBP_OVR_BIT] |-> coax_tx_en_o == $past(link))
    else $error("coax enable does not follow link");
  link_event_a: assert property ($rose(link) |=> irq_stat_ff[0]) // R12
    else $error("link rise not recorded");
  pass_flow_a: assert property (pass_mii_s |=> // R10
    phy_tx_o == $past(mac_tx_s) && mac_rx_o == $past(phy_rx_s))
    else $error("passthrough data not forwarded");
  rmii_hold_a: assert property (mode == `EMBP_MODE_PASS && rmii && // R11
    !ref_rise |=> $stable(phy_tx_o) && $stable(mac_rx_o))
    else $error("rmii passthrough changed off reference edge");
  mac_send_a: assert property (mode == `EMBP_MODE_MAC && tx_tick |=> // R1
    usr_tx_take_o && phy_tx_o.d == $past(usr_tx_i.d))
    else $error("mac role nibble not sent");
  irq_level_a: assert property (|(irq_stat_ff & irq_mask_ff) |=> irq_o)
    else $error("interrupt not raised");
  addr_map_a: assert property (phy_addr[4:2] == addr_reg_ff[6:4]) // R5
    else $error("phy address high bits wrong");

endmodule

//--- testbench/embp_phy_model.sv
// External PHY stand-in: answers management reads with a link bit.
// Assumes mdc_i comes from the bridge and the data line has a pull-up.
`timescale 1ns/1ps
module embp_phy_model (
  input  wire logic       sys_rst_i,
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  input  wire logic       mdio_oe_i,
  input  wire logic       link_i,
  input  wire logic [4:0] my_addr_i,
  output logic            line_o,
  output logic [4:0]      seen_addr_o
);
  // ----------------
  // Frame tracking
  // ----------------
  logic [6:0]  n_ff;
  logic [6:0]  cur_ff;
  logic        run;
  logic        talk;
  logic [15:0] word;
  assign run = (n_ff != 7'h00) || mdio_oe_i;
  // Bits counted on the rising edge, where the master's data is stable
  always_ff @(posedge mdc_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      n_ff        <= 7'h00;
      cur_ff      <= 7'h7f;
      seen_addr_o <= 5'h00;
    end else begin
      cur_ff <= run ? n_ff : 7'h7f;
      n_ff   <= (!run || n_ff == 7'h3f) ? 7'h00 : n_ff + 7'h01;
      if (n_ff > 7'h23 && n_ff < 7'h29) begin
        seen_addr_o <= {seen_addr_o[3:0], mdio_i};
      end
    end
  end
  // status word, link in bit 2
  assign word = {13'h0f01, link_i, 2'h1};
  // answer only at the matching address
  // Each bit is put out after the rising edge before the one that samples it
  assign talk = cur_ff > 7'h2d && cur_ff < 7'h3f && seen_addr_o == my_addr_i;
  // Released line goes to the pull-up level, never the last bit
  assign line_o = mdio_oe_i ? mdio_i
                : talk ? (cur_ff != 7'h2e) & word[4'(7'h3e - cur_ff)] : 1'h1;
endmodule

//--- testbench/ethernet_mii_rmii_bridge_port_test.sv
// Bench for the bridge port: registers, link polling, passthrough.
// Assumes the PHY stand-in model and a free 40 MHz core clock.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module ethernet_mii_rmii_bridge_port_test;
  // ----------------
  // Signals
  // ----------------
  logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er, link, ref_run;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic addr_strap_hi_pin_i, addr_strap_lo_pin_i, mdc_o, mdio_i, mdio_o, mdio_oe_o, pm;
  logic phy_ref_clk_i, aux_ref_clk_i, phy_rx_clk_i, phy_tx_clk_i, mac_rx_clk_o, mac_tx_clk_o;
  logic usr_tx_take_o, usr_rx_stb_o, coax_tx_en_o, coax_rx_en_o, irq_o;
  embp_pkg::embp_nib_type phy_rx_i, phy_tx_o, mac_rx_o, mac_tx_i, usr_tx_i, usr_rx_o, old;
  logic [4:0] seen;
  logic [2:0] cc, a;
  logic [7:0] n1, n2, n3;
  logic [7:0] ixs [4] = '{8'h01, 8'h1e, 8'h26, 8'h44};
  int seed, miscompares, total_checks, i;

  embp_top dut_u (.clk_i, .sys_rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .addr_strap_hi_pin_i, .addr_strap_lo_pin_i, .mdc_o,
    .mdio_i, .mdio_o, .mdio_oe_o, .phy_ref_clk_i, .aux_ref_clk_i, .phy_rx_clk_i, .phy_rx_i,
    .phy_tx_clk_i, .phy_tx_o, .mac_rx_clk_o, .mac_rx_o, .mac_tx_clk_o, .mac_tx_i, .usr_tx_i,
    .usr_tx_take_o, .usr_rx_o, .usr_rx_stb_o, .coax_tx_en_o, .coax_rx_en_o, .irq_o);
  embp_phy_model phy_u (.sys_rst_i, .mdc_i(mdc_o), .mdio_i(mdio_o), .mdio_oe_i(mdio_oe_o),
    .link_i(link), .my_addr_i({a, addr_strap_hi_pin_i, addr_strap_lo_pin_i}), .line_o(mdio_i),
    .seen_addr_o(seen));

  // ----------------
  // Clocks and tasks
  // ----------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Link clocks of 200 ns; the reference can be held still
  always @(posedge clk_i) begin
    cc <= cc + 3'h1;
    phy_rx_clk_i <= cc[2];
    phy_tx_clk_i <= cc[2];
    phy_ref_clk_i <= cc[2] & ref_run;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; an idle cycle follows so strobes never clash
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    int k;
    psel_i <= 1'b1;
    paddr_i <= {2'h0, ix, 2'h0};
    pwrite_i <= w;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k == 16) begin miscompares++; results(); end
    @(posedge clk_i);
  endtask
  task automatic waitirq();
    int k;
    for (k = 0; k < 3000 && irq_o !== 1'b1; k++) @(posedge clk_i);
    if (irq_o !== 1'b1) begin miscompares++; results(); end
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {cc, ref_run, link, sys_rst_i} = 6'h05;
    seed = 32'd8796;
    miscompares = 0;
    total_checks = 0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, aux_ref_clk_i} = '0;
    {usr_tx_i, phy_rx_i, mac_tx_i, phy_rx_clk_i, phy_tx_clk_i, phy_ref_clk_i} = '0;
    {a, addr_strap_hi_pin_i, addr_strap_lo_pin_i} = 5'($random(seed));
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, ixs[i], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b0, 8'h02, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, 8'h49, 32'h7);
    apb(1'b1, 8'h1e, {25'h0, a, 4'h0});
    link <= 1'b1;
    waitirq();
    apb(1'b0, 8'h48, 32'h0);
    `CHK("irq up", 32'h5, rd)
    `CHK("phy addr", {a, addr_strap_hi_pin_i, addr_strap_lo_pin_i}, seen)
    apb(1'b0, 8'h44, 32'h0);
    `CHK("status up", 32'h8, rd)
    `CHK("coax auto", 2'h3, {coax_tx_en_o, coax_rx_en_o})
    // Count high cycles and rises of the management clock
    {n1, n2, pm} = {16'h0, mdc_o};
    for (i = 0; i < 64; i++) begin
      @(posedge clk_i);
      n1 += 8'(mdc_o);
      n2 += 8'(mdc_o & !pm);
      pm = mdc_o;
    end
    `CHK("mdc high", 8'd32, n1)
    `CHK("mdc rises", 8'd8, n2)
    apb(1'b1, 8'h48, 32'h7);
    repeat (3) @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq_o)
    link <= 1'b0;
    waitirq();
    apb(1'b0, 8'h48, 32'h0);
    `CHK("irq down", 32'h6, rd)
    apb(1'b0, 8'h44, 32'h0);
    `CHK("status down", 32'h0, rd)
    `CHK("coax off", 2'h0, {coax_tx_en_o, coax_rx_en_o})
    apb(1'b1, 8'h26, 32'h19);
    apb(1'b1, 8'h49, 32'h0);
    repeat (3) @(posedge clk_i);
    `CHK("coax manual", 2'h3, {coax_tx_en_o, coax_rx_en_o})
    `CHK("irq masked", 1'b0, irq_o)
    apb(1'b1, 8'h01, 32'h10);
    for (i = 0; i < 6; i++) begin
      phy_rx_i <= 6'($random(seed));
      mac_tx_i <= 6'($random(seed));
      repeat (8) @(posedge clk_i);
      `CHK("pass rx", phy_rx_i, mac_rx_o)
      `CHK("pass tx", mac_tx_i, phy_tx_o)
    end
    `CHK("mgmt idle", 2'h0, {mdc_o, mdio_oe_o})
    // Reference held low: outputs must not move until it runs
    ref_run <= 1'b0;
    apb(1'b1, 8'h01, 32'h11);
    old = phy_rx_i;
    phy_rx_i <= ~old;
    repeat (10) @(posedge clk_i);
    `CHK("rmii hold", old, mac_rx_o)
    ref_run <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK("rmii pass", phy_rx_i, mac_rx_o)
    // PHY role: local nibble clock, one take and one strobe per tick
    apb(1'b1, 8'h01, 32'h08);
    usr_tx_i <= 6'($random(seed));
    {n1, n2, n3} = 24'h0;
    for (i = 0; i < 64; i++) begin
      @(posedge clk_i);
      n1 += 8'(usr_tx_take_o);
      n2 += 8'(usr_rx_stb_o);
      n3 += 8'(mac_rx_clk_o & mac_tx_clk_o);
    end
    `CHK("phy role tx", usr_tx_i, mac_rx_o)
    `CHK("phy role rx", mac_tx_i, usr_rx_o)
    `CHK("take count", 8'd8, n1)
    `CHK("strobe count", 8'd8, n2)
    `CHK("phy role clk", 8'd32, n3)
    `CHK("mgmt off", 2'h0, {mdc_o, mdio_oe_o})
    results();
  end
endmodule
